//--- hdl/pks_pkg.sv
package pks_pkg;
	// ==========================================================
	// Clock rate and timing figures.
	// ==========================================================
	localparam int unsigned CLK_KHZ = 250000;
	localparam int unsigned ON_PULSE_MS = 500;
	localparam int unsigned OFF_PULSE_MS = 650;
	localparam int unsigned SUPPLY_STABLE_MS = 30;
	localparam int unsigned RESET_MIN_MS = 150;
	localparam int unsigned RESET_MAX_MS = 460;
	// Cycle counts: whole milliseconds times the rate in kHz, so nothing is rounded.
	localparam int unsigned ON_PULSE_CYC = ON_PULSE_MS * CLK_KHZ;
	localparam int unsigned OFF_PULSE_CYC = OFF_PULSE_MS * CLK_KHZ;
	localparam int unsigned SUPPLY_STABLE_CYC = SUPPLY_STABLE_MS * CLK_KHZ;
	localparam int unsigned RESET_MIN_CYC = RESET_MIN_MS * CLK_KHZ;
	localparam int unsigned RESET_MAX_CYC = RESET_MAX_MS * CLK_KHZ;
	// Module-side shutdown duration, a plain default.
	localparam int unsigned SHUTDOWN_CYC = 1000;
	localparam int unsigned BOOT_CYC = 1000;
	localparam int unsigned CNT_W = 32;

	// ==========================================================
	// Sequencer states, Gray coded along the usual path.
	// ==========================================================
	typedef enum logic [1:0] {
		PKS_OFF = 2'h0,
		PKS_POWERING_ON = 2'h1,
		PKS_ON = 2'h3,
		PKS_POWERING_OFF = 2'h2
	} pks_state_t;
endpackage

//--- hdl/pks_link_if.sv
// ==========================================================
// Power key, reset and status wires between host and module.
// ==========================================================
interface pks_link_if;
	logic power_key_input_o;
	logic power_key_input_oe_n;
	logic reset_input_o;
	logic reset_input_oe_n;
	logic status_o;
	logic power_key_input;
	logic reset_input;
	// Open-drain lines with pull-up: low only while the host drives low.
	assign power_key_input = (!power_key_input_oe_n) ? power_key_input_o : 1'b1;
	assign reset_input = (!reset_input_oe_n) ? reset_input_o : 1'b1;
	modport host (
		output power_key_input_o,
		output power_key_input_oe_n,
		output reset_input_o,
		output reset_input_oe_n,
		input status_o
	);
	modport module_end (
		input power_key_input,
		input reset_input,
		output status_o
	);
endinterface

//--- hdl/pks_host.sv
// How it works
// - Hold key low 500ms to power on.
// - Keep key low until status goes high.
// - Wait 30ms stable supply before key.
// - Hold key 650ms to shut down.
// - Power-off command shuts down like key.
// - Keep key high after power-off command; the host presses the key if status stays high past the wait.
// - Reset pulse lasts 150ms to 460ms.
// - Reset only after both shutdowns fail; the host takes i_hard_reset once the key shutdown alone has failed.
// - Remove supply only after completed shutdown.
// - Drive key open-drain: pull low, else release.
// - Status high once module powered on.
module pks_host #(
	parameter int unsigned ON_CYC = pks_pkg::ON_PULSE_CYC,
	parameter int unsigned OFF_CYC = pks_pkg::OFF_PULSE_CYC,
	parameter int unsigned STABLE_CYC = pks_pkg::SUPPLY_STABLE_CYC,
	parameter int unsigned RST_CYC = pks_pkg::RESET_MIN_CYC,
	parameter int unsigned RST_MAX_CYC = pks_pkg::RESET_MAX_CYC,
	parameter int unsigned WAIT_CYC = pks_pkg::OFF_PULSE_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_supply_ok,
	input wire logic i_turn_on,
	input wire logic i_turn_off,
	input wire logic i_soft_off_sent,
	input wire logic i_soft_off_failed,
	input wire logic i_hard_reset,
	output logic o_is_on,
	output logic o_busy,
	output logic o_supply_may_drop,
	output logic o_key_fail,
	pks_link_if.host link
);
	// Elaboration check: zero lengths, a reversed reset window or a
	// shutdown window that overflows the counter cannot be served.
	if (ON_CYC == 0 || OFF_CYC == 0 || STABLE_CYC == 0 || RST_CYC == 0 ||
		RST_CYC > RST_MAX_CYC || WAIT_CYC == 0 ||
		(64'(OFF_CYC) + 64'(WAIT_CYC)) >= (64'h1 << pks_pkg::CNT_W)) begin : g_bad_timing
		$error("pks_host: bad timing parameters");
	end

	// ==========================================================
	// Status sampling.
	// ==========================================================
	// Three stages; a change counts once the last two agree.
	logic [2:0] st_sync_q;
	logic st_q;
	logic st_d;
	always_comb begin
		st_d = st_q;
		if (st_sync_q[1] == st_sync_q[2]) begin
			st_d = st_sync_q[2];
		end
	end
	// Shift the pin in and keep the agreed level.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_sync_q <= 3'h0;
			st_q <= 1'b0;
		end else begin
			st_sync_q <= {st_sync_q[1:0], link.status_o};
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Sequencer.
	// ==========================================================
	pks_pkg::pks_state_t state_q, state_d;
	logic [pks_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic [pks_pkg::CNT_W-1:0] stab_q, stab_d;
	logic key_low_q, key_low_d;
	logic rst_low_q, rst_low_d;
	logic off_done_q, off_done_d;
	logic key_fail_q, key_fail_d;
	logic soft_q, soft_d;
	logic stable;
	assign stable = (stab_q >= pks_pkg::CNT_W'(STABLE_CYC));

	// Next state, counters and pin requests.
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		key_low_d = 1'b0;
		rst_low_d = 1'b0;
		off_done_d = off_done_q;
		key_fail_d = key_fail_q;
		soft_d = soft_q;
		// Supply must stay good without a break for the whole wait.
		stab_d = i_supply_ok ? ((stable) ? stab_q : stab_q + 1'b1) : '0;
		case (state_q)
			pks_pkg::PKS_OFF: begin
				cnt_d = '0;
				if (rst_low_q && cnt_q < pks_pkg::CNT_W'(RST_CYC)) begin
					// Finish a reset pulse already under way.
					rst_low_d = 1'b1;
					cnt_d = cnt_q + 1'b1;
				end else if (i_turn_on && stable && !st_q) begin
					state_d = pks_pkg::PKS_POWERING_ON;
					off_done_d = 1'b0;
					key_fail_d = 1'b0;
				end else if (st_q) begin
					// A module found running with no press of ours is adopted as on.
					state_d = pks_pkg::PKS_ON;
				end
			end
			pks_pkg::PKS_POWERING_ON: begin
				key_low_d = 1'b1;
				if (cnt_q < pks_pkg::CNT_W'(ON_CYC)) begin
					cnt_d = cnt_q + 1'b1;
				end
				// Release after the minimum and the status answer, or at once if the supply drops.
				if (cnt_q >= pks_pkg::CNT_W'(ON_CYC) && st_q) begin
					key_low_d = 1'b0;
					state_d = pks_pkg::PKS_ON;
					cnt_d = '0;
				end
				if (!i_supply_ok) begin
					key_low_d = 1'b0;
					state_d = pks_pkg::PKS_OFF;
				end
			end
			pks_pkg::PKS_ON: begin
				cnt_d = '0;
				soft_d = 1'b0;
				if (i_soft_off_sent) begin
					// Key stays released; only status is watched.
					soft_d = 1'b1;
					state_d = pks_pkg::PKS_POWERING_OFF;
				end else if (i_turn_off) begin
					state_d = pks_pkg::PKS_POWERING_OFF;
				end
			end
			pks_pkg::PKS_POWERING_OFF: begin
				// Press for the off time, then give the module a window to finish.
				cnt_d = cnt_q + 1'b1;
				key_low_d = !soft_q && cnt_q < pks_pkg::CNT_W'(OFF_CYC);
				if (!st_q && !key_low_d) begin
					state_d = pks_pkg::PKS_OFF;
					off_done_d = 1'b1;
					cnt_d = '0;
				end else if (cnt_q >= pks_pkg::CNT_W'(OFF_CYC + WAIT_CYC)) begin
					if (soft_q || !i_soft_off_failed) begin
						// Soft path failed: fall back to the key; a failed key press returns to on with key_fail set.
						soft_d = 1'b0;
						cnt_d = '0;
						if (!soft_q) begin
							key_fail_d = 1'b1;
							state_d = pks_pkg::PKS_ON;
						end
					end else begin
						// Both shutdowns failed: pulse reset as last resort.
						state_d = pks_pkg::PKS_OFF;
						rst_low_d = 1'b1;
						key_fail_d = 1'b1;
						cnt_d = '0;
					end
				end
			end
			default: begin
				state_d = pks_pkg::PKS_OFF;
			end
		endcase
		if (i_hard_reset && state_q == pks_pkg::PKS_ON && key_fail_q) begin
			state_d = pks_pkg::PKS_OFF;
			rst_low_d = 1'b1;
			key_low_d = 1'b0;
			cnt_d = '0;
		end
	end

	// Registers only; every bit resets to its idle value.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= pks_pkg::PKS_OFF;
			cnt_q <= '0;
			stab_q <= '0;
			key_low_q <= 1'b0;
			rst_low_q <= 1'b0;
			off_done_q <= 1'b0;
			key_fail_q <= 1'b0;
			soft_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			stab_q <= stab_d;
			key_low_q <= key_low_d;
			rst_low_q <= rst_low_d;
			off_done_q <= off_done_d;
			key_fail_q <= key_fail_d;
			soft_q <= soft_d;
		end
	end

	// Open-drain drive: data held low, enable asserted (low) only to pull.
	assign link.power_key_input_o = 1'b0;
	assign link.power_key_input_oe_n = !key_low_q;
	assign link.reset_input_o = 1'b0;
	assign link.reset_input_oe_n = !rst_low_q;
	// Status outputs decode the registered state and flags directly.
	assign o_is_on = (state_q == pks_pkg::PKS_ON);
	assign o_busy = (state_q == pks_pkg::PKS_POWERING_ON) ||
		(state_q == pks_pkg::PKS_POWERING_OFF) || rst_low_q;
	assign o_supply_may_drop = off_done_q && state_q == pks_pkg::PKS_OFF;
	assign o_key_fail = key_fail_q;
endmodule

//--- hdl/pks_module.sv
// ==========================================================
// Module end: responds to key, reset and power-off command.
// ==========================================================
module pks_module #(
	parameter int unsigned ON_CYC = pks_pkg::ON_PULSE_CYC,
	parameter int unsigned OFF_CYC = pks_pkg::OFF_PULSE_CYC,
	parameter int unsigned RST_CYC = pks_pkg::RESET_MIN_CYC,
	parameter int unsigned SHUT_CYC = pks_pkg::SHUTDOWN_CYC,
	parameter int unsigned BOOTC = pks_pkg::BOOT_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_power_off_command,
	output logic o_running,
	output logic o_resetting,
	pks_link_if.module_end link
);
	// Elaboration check: zero press, reset or shutdown lengths cannot be served.
	if (ON_CYC == 0 || OFF_CYC == 0 || RST_CYC == 0 || SHUT_CYC == 0) begin : g_bad_timing
		$error("pks_module: bad timing parameters");
	end

	// ==========================================================
	// Pin sampling, three stages each.
	// ==========================================================
	logic [2:0] key_sync_q, rst_sync_q;
	logic key_q, key_d, rin_q, rin_d;
	always_comb begin
		key_d = (key_sync_q[1] == key_sync_q[2]) ? key_sync_q[2] : key_q;
		rin_d = (rst_sync_q[1] == rst_sync_q[2]) ? rst_sync_q[2] : rin_q;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			key_sync_q <= 3'h7;
			rst_sync_q <= 3'h7;
			key_q <= 1'b1;
			rin_q <= 1'b1;
		end else begin
			key_sync_q <= {key_sync_q[1:0], link.power_key_input};
			rst_sync_q <= {rst_sync_q[1:0], link.reset_input};
			key_q <= key_d;
			rin_q <= rin_d;
		end
	end

	// ==========================================================
	// Power state machine.
	// ==========================================================
	pks_pkg::pks_state_t state_q, state_d;
	logic [pks_pkg::CNT_W-1:0] kcnt_q, kcnt_d, rcnt_q, rcnt_d, cnt_q, cnt_d;
	logic armed_q, armed_d;
	logic rst_hit;
	// A reset pulse is acted on once released after the minimum width.
	assign rst_hit = rin_q && rcnt_q >= pks_pkg::CNT_W'(RST_CYC);

	always_comb begin
		state_d = state_q;
		cnt_d = '0;
		armed_d = armed_q;
		kcnt_d = key_q ? '0 : ((kcnt_q == '1) ? kcnt_q : kcnt_q + 1'b1);
		rcnt_d = rin_q ? '0 : ((rcnt_q == '1) ? rcnt_q : rcnt_q + 1'b1);
		case (state_q)
			pks_pkg::PKS_OFF: begin
				armed_d = 1'b0;
				if (kcnt_q >= pks_pkg::CNT_W'(ON_CYC)) begin
					state_d = pks_pkg::PKS_POWERING_ON;
				end
			end
			pks_pkg::PKS_POWERING_ON: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= pks_pkg::CNT_W'(BOOTC)) begin
					state_d = pks_pkg::PKS_ON;
					cnt_d = '0;
				end
			end
			pks_pkg::PKS_ON: begin
				// The turn-on press must be released before a new press counts.
				if (key_q) begin
					armed_d = 1'b1;
				end
				if (i_power_off_command) begin
					state_d = pks_pkg::PKS_POWERING_OFF;
				end else if (armed_q && key_q && kcnt_q >= pks_pkg::CNT_W'(OFF_CYC)) begin
					state_d = pks_pkg::PKS_POWERING_OFF;
				end
			end
			pks_pkg::PKS_POWERING_OFF: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= pks_pkg::CNT_W'(SHUT_CYC)) begin
					state_d = pks_pkg::PKS_OFF;
					cnt_d = '0;
				end
			end
			default: begin
				state_d = pks_pkg::PKS_OFF;
			end
		endcase
		if (rst_hit && state_q != pks_pkg::PKS_OFF) begin
			state_d = pks_pkg::PKS_POWERING_ON;
			cnt_d = '0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= pks_pkg::PKS_OFF;
			kcnt_q <= '0;
			rcnt_q <= '0;
			cnt_q <= '0;
			armed_q <= 1'b0;
		end else begin
			state_q <= state_d;
			kcnt_q <= kcnt_d;
			rcnt_q <= rcnt_d;
			cnt_q <= cnt_d;
			armed_q <= armed_d;
		end
	end

	// Status is high while running, and stays high through shutdown.
	logic status_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status_q <= 1'b0;
		end else begin
			status_q <= (state_d == pks_pkg::PKS_ON) || (state_d == pks_pkg::PKS_POWERING_OFF);
		end
	end
	assign link.status_o = status_q;
	assign o_running = (state_q == pks_pkg::PKS_ON);
	assign o_resetting = !rin_q;
endmodule

//--- sim/pks_checker.sv
// ==========================================================
// Wire-level checks on the power key and reset lines.
// ==========================================================
module pks_checker #(
	parameter int unsigned ON_CYC = 20,
	parameter int unsigned OFF_CYC = 30,
	parameter int unsigned RST_CYC = 20,
	parameter int unsigned RST_MAX_CYC = 40,
	parameter int unsigned SHUT_CYC = 30,
	parameter int unsigned BOOTC = 20
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic power_key_input_o,
	input wire logic power_key_input_oe_n,
	input wire logic reset_input_o,
	input wire logic reset_input_oe_n,
	input wire logic status_o,
	input wire logic power_key_input,
	input wire logic reset_input
);
	// Slack covers the module's three-stage key synchroniser and its registered status.
	localparam int SHUT_MAX = SHUT_CYC + 16;
	localparam int BOOT_MAX = ON_CYC + BOOTC + 16;
	logic [31:0] key_cnt_q, key_cnt_d, rst_cnt_q, rst_cnt_d;
	logic press_on_q, press_on_d;
	// Low-time counters, and whether the current press began with the module off.
	always_comb begin
		key_cnt_d = power_key_input ? 32'h0 : key_cnt_q + 32'h1;
		rst_cnt_d = reset_input ? 32'h0 : rst_cnt_q + 32'h1;
		press_on_d = (!power_key_input && key_cnt_q == 32'h0) ? !status_o : press_on_q;
	end
	// Registers only.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			key_cnt_q <= 32'h0;
			rst_cnt_q <= 32'h0;
			press_on_q <= 1'b0;
		end else begin
			key_cnt_q <= key_cnt_d;
			rst_cnt_q <= rst_cnt_d;
			press_on_q <= press_on_d;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_on_rel;
		$rose(power_key_input) && press_on_q;
	endsequence
	sequence s_off_rel;
		$rose(power_key_input) && !press_on_q;
	endsequence
	property p_one_pulse;
		!(!power_key_input_oe_n && !reset_input_oe_n);
	endproperty
	property p_key_od;
		!power_key_input_oe_n |-> !power_key_input_o;
	endproperty
	property p_rst_od;
		!reset_input_oe_n |-> !reset_input_o;
	endproperty
	property p_release_status;
		$rose(power_key_input) |-> status_o;
	endproperty
	property p_on_width;
		s_on_rel |-> key_cnt_q >= 32'(ON_CYC);
	endproperty
	property p_off_width;
		s_off_rel |-> key_cnt_q >= 32'(OFF_CYC);
	endproperty
	property p_shutdown;
		s_off_rel |-> ##[1:SHUT_MAX] !status_o;
	endproperty
	property p_boot;
		(!power_key_input && press_on_q && key_cnt_q > 32'(BOOT_MAX)) |-> status_o;
	endproperty
	property p_rst_width;
		$rose(reset_input) |-> rst_cnt_q >= 32'(RST_CYC) && rst_cnt_q <= 32'(RST_MAX_CYC);
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("both lines pulled");
	a_key_od: assert property (p_key_od) else $error("key driven high");
	a_rst_od: assert property (p_rst_od) else $error("reset driven high");
	a_release_status: assert property (p_release_status) else $error("early release");
	a_on_width: assert property (p_on_width) else $error("on press short");
	a_off_width: assert property (p_off_width) else $error("off press short");
	a_shutdown: assert property (p_shutdown) else $error("no shutdown");
	a_boot: assert property (p_boot) else $error("status not raised");
	a_rst_width: assert property (p_rst_width) else $error("reset width bad");
endmodule

//--- sim/pks_tb_top.sv
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
	$display("[ERR] %0t got=%0h exp=%0h", $time, a, e); end end
// ==========================================================
// Host and module joined back to back.
// ==========================================================
module pks_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned STABLE = 25;
	localparam int unsigned ON_T = 20;
	localparam int unsigned OFF_T = 30;
	localparam int unsigned RST_T = 20;
	localparam int unsigned RST_MAX_T = 40;
	localparam int unsigned WAIT_T = 200;
	localparam int unsigned SHUT_T = 30;
	localparam int unsigned BOOT_T = 20;
	logic i_clk, i_rst_n, sup, t_on, t_off, s_sent, s_fail, h_rst, p_off;
	logic is_on, busy, may_drop, key_fail, running, resetting, key_seen;
	int fails, checked, c;
	pks_link_if link ();
	pks_host #(.ON_CYC(ON_T), .OFF_CYC(OFF_T), .STABLE_CYC(STABLE), .RST_CYC(RST_T),
		.RST_MAX_CYC(RST_MAX_T), .WAIT_CYC(WAIT_T)) pks_host_inst (.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_supply_ok(sup), .i_turn_on(t_on), .i_turn_off(t_off), .i_soft_off_sent(s_sent),
		.i_soft_off_failed(s_fail), .i_hard_reset(h_rst), .o_is_on(is_on), .o_busy(busy),
		.o_supply_may_drop(may_drop), .o_key_fail(key_fail), .link(link));
	pks_module #(.ON_CYC(ON_T), .OFF_CYC(OFF_T), .RST_CYC(RST_T), .SHUT_CYC(SHUT_T),
		.BOOTC(BOOT_T)) pks_module_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_power_off_command(p_off),
		.o_running(running), .o_resetting(resetting), .link(link));
	pks_checker #(.ON_CYC(ON_T), .OFF_CYC(OFF_T), .RST_CYC(RST_T), .RST_MAX_CYC(RST_MAX_T),
		.SHUT_CYC(SHUT_T), .BOOTC(BOOT_T)) pks_checker_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.power_key_input_o(link.power_key_input_o),
		.power_key_input_oe_n(link.power_key_input_oe_n),
		.reset_input_o(link.reset_input_o), .reset_input_oe_n(link.reset_input_oe_n),
		.status_o(link.status_o), .power_key_input(link.power_key_input),
		.reset_input(link.reset_input));
	task automatic finish_test();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Waits for a settled state; a timeout ends the run as a failure.
	task automatic wait_on(input logic want);
		c = 0;
		key_seen = 1'b0;
		while (is_on !== want || busy !== 1'b0) begin
			@(negedge i_clk);
			c++;
			if (link.power_key_input === 1'b0) key_seen = 1'b1;
			if (c > 2000) begin
				fails++;
				finish_test();
			end
		end
	endtask
	// Free-running 250 MHz clock.
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	// Main sequence; inputs change on the falling edge.
	initial begin
		{i_rst_n, sup, t_on, t_off, s_sent, s_fail, h_rst, p_off} = 8'h0;
		fails = 0;
		checked = 0;
		repeat (16) @(negedge i_clk);
		i_rst_n = 1'b1;
		`CHK({link.power_key_input, link.reset_input, link.status_o}, 3'h6)
		t_on = 1'b1;
		repeat (30) @(negedge i_clk);
		`CHK(link.power_key_input, 1'b1)
		sup = 1'b1;
		c = 0;
		while (link.power_key_input !== 1'b0 && c < 500) begin
			@(negedge i_clk);
			c++;
		end
		`CHK(c >= STABLE && c < 500, 1'b1)
		if (c >= 500) begin
			finish_test();
		end
		wait_on(1'b1);
		t_on = 1'b0;
		`CHK({link.status_o, running, link.power_key_input, may_drop}, 4'he)
		$display("power on done");
		h_rst = 1'b1;
		repeat (50) begin
			@(negedge i_clk);
			`CHK({link.reset_input, resetting}, 2'h2)
		end
		h_rst = 1'b0;
		$display("early reset refusal done");
		t_off = 1'b1;
		wait_on(1'b0);
		t_off = 1'b0;
		`CHK({link.status_o, running, may_drop, key_fail}, 4'h2)
		$display("key power off done");
		t_on = 1'b1;
		wait_on(1'b1);
		t_on = 1'b0;
		p_off = 1'b1;
		s_sent = 1'b1;
		@(negedge i_clk);
		p_off = 1'b0;
		s_sent = 1'b0;
		wait_on(1'b0);
		`CHK({key_seen, running, link.status_o, may_drop}, 4'h1)
		$display("command power off done");
		// A command that never reaches the module: after the wait window
		// the host must fall back to the key, not to the reset line.
		t_on = 1'b1;
		wait_on(1'b1);
		t_on = 1'b0;
		s_sent = 1'b1;
		s_fail = 1'b1;
		@(negedge i_clk);
		s_sent = 1'b0;
		repeat (OFF_T + WAIT_T - 2) begin
			@(negedge i_clk);
			`CHK({link.power_key_input, link.reset_input, link.status_o, busy}, 4'hf)
		end
		wait_on(1'b0);
		s_fail = 1'b0;
		`CHK({key_seen, running, may_drop, key_fail, resetting}, 5'h14)
		$display("key fallback after lost command done");
		finish_test();
	end
endmodule
